/* design/lfit_pkg.sv */
// Constants, register map and code tables for the flash/indicator timing block
package lfit_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFF_FLASH_TORCH_TIMING = 8'h0b;
    localparam logic [7:0] OFF_INDICATOR_RAMP_TIMING = 8'h0c;
    localparam logic [7:0] OFF_INDICATOR_ON_OFF_TIMING = 8'h0d;
    localparam logic [7:0] OFF_INDICATOR_CONTROL = 8'h0e;
    localparam logic [7:0] OFF_FAULT_FLAGS = 8'h0f;
    localparam logic [7:0] OFF_DEVICE_IDENTITY = 8'h10;
    localparam logic [7:0] OFF_INDICATOR_LEVEL_LOW = 8'h11;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_FLASH_TORCH_TIMING = 8'h1a;
    localparam logic [7:0] RST_INDICATOR_RAMP_TIMING = 8'h77;
    localparam logic [7:0] RST_INDICATOR_ON_OFF_TIMING = 8'h55;
    localparam logic [7:0] RST_INDICATOR_CONTROL = 8'h00;
    localparam logic [7:0] RST_FAULT_FLAGS = 8'h00;
    localparam logic [1:0] RST_INDICATOR_LEVEL_LOW = 2'h3;
    // Arbitrary neutral identity value
    localparam logic [7:0] DEVICE_IDENTITY_DEFAULT = 8'h5a;
    // Reserved bits of the level-low register read as ones
    localparam logic [5:0] LEVEL_LOW_RESERVED_BITS = 6'h3f;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int HI_MSB = 7;
    localparam int HI_LSB = 4;
    localparam int LO_MSB = 3;
    localparam int LO_LSB = 0;
    localparam int CTL_SHAPE_BIT = 3;
    localparam int CTL_STATE_MSB = 2;
    localparam int CTL_STATE_LSB = 1;
    localparam int CTL_ENABLE_BIT = 0;
    localparam int FLG_FLASH_TIMEOUT = 7;
    localparam int FLG_INPUT_VOLTAGE_FLASH_MONITOR = 6;
    localparam int FLG_LED_SHORT = 2;
    localparam int FLG_THERMAL_SHUTDOWN = 1;
    localparam int FLG_UNDERVOLTAGE_LOCKOUT = 0;
    localparam logic [7:0] FLAGS_IMPL_MASK = 8'hc7;

    // Indicator state selections
    localparam logic [1:0] IND_STANDBY = 2'h0;
    localparam logic [1:0] IND_CONSTANT_ON = 2'h1;
    localparam logic [1:0] IND_BREATH_TO_STANDBY = 2'h2;
    localparam logic [1:0] IND_BREATH_TO_ON = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_IN_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
    localparam logic [7:0] LEVEL_FULL = 8'hff;
    localparam logic [12:0] RAMP_STEP = 13'h00ff;

    // Ramp code to milliseconds, shared by torch and indicator ramps
    function automatic logic [11:0] ramp_ms(input logic [3:0] code);
        case (code)
            4'h0: ramp_ms = 12'd0;
            4'h1: ramp_ms = 12'd1;
            4'h2: ramp_ms = 12'd32;
            4'h3: ramp_ms = 12'd64;
            4'h4: ramp_ms = 12'd128;
            4'h5: ramp_ms = 12'd256;
            4'h6: ramp_ms = 12'd384;
            4'h7: ramp_ms = 12'd512;
            4'h8: ramp_ms = 12'd768;
            4'h9: ramp_ms = 12'd1024;
            4'ha: ramp_ms = 12'd1280;
            4'hb: ramp_ms = 12'd1536;
            4'hc: ramp_ms = 12'd1792;
            default: ramp_ms = 12'd2048;
        endcase
    endfunction : ramp_ms

    // Indicator on/off code to milliseconds
    function automatic logic [12:0] on_off_ms(input logic [3:0] code);
        case (code)
            4'h0: on_off_ms = 13'd64;
            4'h1: on_off_ms = 13'd128;
            4'h2: on_off_ms = 13'd256;
            4'h3: on_off_ms = 13'd512;
            4'h4: on_off_ms = 13'd768;
            4'h5: on_off_ms = 13'd1024;
            4'h6: on_off_ms = 13'd1280;
            4'h7: on_off_ms = 13'd1536;
            4'h8: on_off_ms = 13'd1792;
            4'h9: on_off_ms = 13'd2048;
            4'ha: on_off_ms = 13'd2560;
            4'hb: on_off_ms = 13'd3072;
            4'hc: on_off_ms = 13'd3584;
            4'hd: on_off_ms = 13'd4096;
            4'he: on_off_ms = 13'd4608;
            default: on_off_ms = 13'd5120;
        endcase
    endfunction : on_off_ms

    // Flash time-out code to milliseconds; gap codes hold the 400 ms step
    function automatic logic [10:0] flash_timeout_ms(input logic [3:0] code);
        case (code)
            4'hd: flash_timeout_ms = 11'd1200;
            4'he: flash_timeout_ms = 11'd1400;
            4'hf: flash_timeout_ms = 11'd1600;
            4'ha, 4'hb, 4'hc: flash_timeout_ms = 11'd400;
            default: flash_timeout_ms = 11'((code + 11'd1) * 11'd40);
        endcase
    endfunction : flash_timeout_ms

endpackage : lfit_pkg

/* design/lfit_regs.sv */
// Timing registers, fault flags and indicator breathing sequencer
//
// Operation
// - Torch ramp code in flash/torch timing bits 7:4; 0 none, 1 is 1 ms.
// - Torch ramp codes up to 1100 lengthen ramp; 1101-1111 give 2048 ms.
// - Flash time-out in bits 3:0; codes 0-9 give 40 to 400 ms.
// - Time-out codes 1101-1111 give 1200/1400/1600 ms; register resets 0x1a.
// - Indicator ramp-up in ramp timing bits 7:4, same table; reset 0x77.
// - Indicator ramp-down in bits 3:0, same table; 1101 upward is 2048 ms.
// - Indicator on-time in on/off bits 7:4, sixteen steps 64 to 5120 ms.
// - Indicator off-time in bits 3:0, same table; register resets 0x55.
// - Repeat count in control bits 7:4; zero means breathe forever.
// - Control bit 3 picks linear (0) or exponential (1) ramp shape.
// - Control bits 2:1 pick indicator state; bit 0 enables, reset 0.
// - Flags bit 7 flash time-out, bit 6 voltage monitor trip; reset 0.
// - Flags bit 2 LED short, bit 1 thermal shutdown, bit 0 undervoltage.
// - Read-only identity register at 0x10 returns a fixed code.
// - Register 0x11 holds two level bits, reserved upper bits, reset 0xff.
// - Strobe input acts on level when type bit is 0, edge when 1.
// - Register address advances by one after each data byte.
`timescale 1ns/1ps
`default_nettype none

module lfit_regs #(
    parameter int CYC_PER_MS = lfit_pkg::CYCLES_PER_MS,
    parameter logic [7:0] DEVICE_IDENTITY = lfit_pkg::DEVICE_IDENTITY_DEFAULT
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic soft_reset,
    // Byte port from the serial engine
    input wire logic host_addr_load,
    input wire logic [7:0] host_addr,
    input wire logic host_wr_stb,
    input wire logic [7:0] host_wr_data,
    input wire logic host_rd_stb,
    output logic [7:0] host_rd_data_q,
    output logic host_rd_valid_q,
    // Fault conditions from analog, asynchronous
    input wire logic flash_timeout_cond,
    input wire logic input_voltage_flash_monitor_cond,
    input wire logic led_short_cond,
    input wire logic thermal_shutdown_cond,
    input wire logic undervoltage_lockout_cond,
    // Hardware strobe, asynchronous pin, and its type select
    input wire logic strobe_pin,
    input wire logic strobe_edge_mode,
    output logic strobe_trigger_q,
    // Decoded timing for the flash/torch current stage
    output logic [11:0] torch_ramp_ms_q,
    output logic [10:0] flash_timeout_ms_q,
    // Indicator drive
    output logic [7:0] ind_level_q,
    output logic [1:0] ind_level_low_q,
    output logic ind_breathing_q,
    output logic ind_breath_done_q
);

    if (CYC_PER_MS < 1 || CYC_PER_MS >= (1 << 17)) begin : g_bad_cyc
        $error("CYC_PER_MS out of range");
    end

    typedef enum logic [2:0] {B_IDLE, B_UP, B_ON, B_DOWN, B_OFF, B_HOLD} lfit_state_e;

    typedef struct packed {
        logic [7:0] ft;
        logic [7:0] rt;
        logic [7:0] oo;
        logic [7:0] ctl;
        logic [1:0] lvl_lo;
        logic [7:0] flags;
        logic [7:0] addr;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [2:0] stb_sync;
        logic stb_lvl;
        logic stb_trig;
        logic [4:0] c1;
        logic [4:0] c2;
        logic [4:0] c3;
        logic [16:0] ms_cnt;
        logic ms_tick;
        lfit_state_e st;
        logic [12:0] ph_ms;
        logic [12:0] acc;
        logic [7:0] lin;
        logic [7:0] level;
        logic [3:0] cycles;
        logic done;
        logic [11:0] torch_ms;
        logic [10:0] fto_ms;
        logic breathing;
    } lfit_st_s;

    localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);

    lfit_st_s st_q;
    lfit_st_s st_d;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign host_rd_data_q = st_q.rd_data;
    assign host_rd_valid_q = st_q.rd_valid;
    assign strobe_trigger_q = st_q.stb_trig;
    assign torch_ramp_ms_q = st_q.torch_ms;
    assign flash_timeout_ms_q = st_q.fto_ms;
    assign ind_level_q = st_q.level;
    assign ind_level_low_q = st_q.lvl_lo;
    assign ind_breathing_q = st_q.breathing;
    assign ind_breath_done_q = st_q.done;

    // Reset image shared by the async and the software reset
    function automatic lfit_st_s reset_image();
        lfit_st_s r;
        r = '0;
        r.ft = lfit_pkg::RST_FLASH_TORCH_TIMING;
        r.rt = lfit_pkg::RST_INDICATOR_RAMP_TIMING;
        r.oo = lfit_pkg::RST_INDICATOR_ON_OFF_TIMING;
        r.ctl = lfit_pkg::RST_INDICATOR_CONTROL;
        r.flags = lfit_pkg::RST_FAULT_FLAGS;
        r.lvl_lo = lfit_pkg::RST_INDICATOR_LEVEL_LOW;
        r.st = B_IDLE;
        r.torch_ms = 12'd1;
        r.fto_ms = 11'd400;
        return r;
    endfunction : reset_image

    logic [7:0] rd_mux;
    logic [11:0] ramp_dur;
    logic [12:0] hold_dur;
    logic [12:0] ph_next;
    logic [7:0] set_bits;
    logic [15:0] sq;
    logic enable;
    logic [1:0] ind_mode;
    logic phase_end;
    logic cycle_last;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_d = st_q;
        enable = st_q.ctl[lfit_pkg::CTL_ENABLE_BIT];
        ind_mode = st_q.ctl[lfit_pkg::CTL_STATE_MSB:lfit_pkg::CTL_STATE_LSB];

        // Read mux; unmapped offsets read zero
        case (st_q.addr)
            lfit_pkg::OFF_FLASH_TORCH_TIMING: rd_mux = st_q.ft;
            lfit_pkg::OFF_INDICATOR_RAMP_TIMING: rd_mux = st_q.rt;
            lfit_pkg::OFF_INDICATOR_ON_OFF_TIMING: rd_mux = st_q.oo;
            lfit_pkg::OFF_INDICATOR_CONTROL: rd_mux = st_q.ctl;
            lfit_pkg::OFF_FAULT_FLAGS: rd_mux = st_q.flags & lfit_pkg::FLAGS_IMPL_MASK;
            lfit_pkg::OFF_DEVICE_IDENTITY: rd_mux = DEVICE_IDENTITY;
            lfit_pkg::OFF_INDICATOR_LEVEL_LOW: rd_mux = {lfit_pkg::LEVEL_LOW_RESERVED_BITS, st_q.lvl_lo};
            default: rd_mux = 8'h00;
        endcase

        // Host byte port; address load wins over data in the same cycle
        st_d.rd_valid = 1'b0;
        if (host_addr_load) begin
            st_d.addr = host_addr;
        end else if (host_wr_stb) begin
            case (st_q.addr)
                lfit_pkg::OFF_FLASH_TORCH_TIMING: st_d.ft = host_wr_data;
                lfit_pkg::OFF_INDICATOR_RAMP_TIMING: st_d.rt = host_wr_data;
                lfit_pkg::OFF_INDICATOR_ON_OFF_TIMING: st_d.oo = host_wr_data;
                lfit_pkg::OFF_INDICATOR_CONTROL: st_d.ctl = host_wr_data;
                lfit_pkg::OFF_INDICATOR_LEVEL_LOW: st_d.lvl_lo = host_wr_data[1:0];
                default: st_d.addr = st_d.addr; // Read-only or unmapped: ignored
            endcase
            st_d.addr = st_q.addr + 8'h01;
        end else if (host_rd_stb) begin
            st_d.rd_data = rd_mux;
            st_d.rd_valid = 1'b1;
            st_d.addr = st_q.addr + 8'h01;
        end

        // Fault inputs: three stages, a level counts once stages two and three agree
        st_d.c1 = {flash_timeout_cond, input_voltage_flash_monitor_cond, led_short_cond,
                   thermal_shutdown_cond, undervoltage_lockout_cond};
        st_d.c2 = st_q.c1;
        st_d.c3 = st_q.c2;
        set_bits = 8'h00;
        set_bits[lfit_pkg::FLG_FLASH_TIMEOUT] = st_q.c2[4] & st_q.c3[4];
        set_bits[lfit_pkg::FLG_INPUT_VOLTAGE_FLASH_MONITOR] = st_q.c2[3] & st_q.c3[3];
        set_bits[lfit_pkg::FLG_LED_SHORT] = st_q.c2[2] & st_q.c3[2];
        set_bits[lfit_pkg::FLG_THERMAL_SHUTDOWN] = st_q.c2[1] & st_q.c3[1];
        set_bits[lfit_pkg::FLG_UNDERVOLTAGE_LOCKOUT] = st_q.c2[0] & st_q.c3[0];
        // Read clears, but a condition present in that cycle keeps its flag
        if (host_rd_stb && !host_addr_load && !host_wr_stb && st_q.addr == lfit_pkg::OFF_FAULT_FLAGS) begin
            st_d.flags = set_bits;
        end else begin
            st_d.flags = st_q.flags | set_bits;
        end

        // Strobe pin filter and trigger
        st_d.stb_sync = {st_q.stb_sync[1:0], strobe_pin};
        if (st_q.stb_sync[1] == st_q.stb_sync[2]) begin
            st_d.stb_lvl = st_q.stb_sync[2];
        end
        if (strobe_edge_mode) begin
            st_d.stb_trig = st_d.stb_lvl & ~st_q.stb_lvl;
        end else begin
            st_d.stb_trig = st_d.stb_lvl;
        end

        // Decoded flash/torch timing
        st_d.torch_ms = lfit_pkg::ramp_ms(st_q.ft[lfit_pkg::HI_MSB:lfit_pkg::HI_LSB]);
        st_d.fto_ms = lfit_pkg::flash_timeout_ms(st_q.ft[lfit_pkg::LO_MSB:lfit_pkg::LO_LSB]);

        // Millisecond time base
        st_d.ms_tick = 1'b0;
        if (st_q.ms_cnt >= MS_LAST) begin
            st_d.ms_cnt = 17'h00000;
            st_d.ms_tick = 1'b1;
        end else begin
            st_d.ms_cnt = st_q.ms_cnt + 17'h00001;
        end

        // Phase durations
        ramp_dur = 12'h000;
        hold_dur = 13'h0000;
        case (st_q.st)
            B_UP: ramp_dur = lfit_pkg::ramp_ms(st_q.rt[lfit_pkg::HI_MSB:lfit_pkg::HI_LSB]);
            B_DOWN: ramp_dur = lfit_pkg::ramp_ms(st_q.rt[lfit_pkg::LO_MSB:lfit_pkg::LO_LSB]);
            B_ON: hold_dur = lfit_pkg::on_off_ms(st_q.oo[lfit_pkg::HI_MSB:lfit_pkg::HI_LSB]);
            B_OFF: hold_dur = lfit_pkg::on_off_ms(st_q.oo[lfit_pkg::LO_MSB:lfit_pkg::LO_LSB]);
            default: hold_dur = 13'h0000;
        endcase
        ph_next = st_q.ph_ms + 13'h0001;
        if (st_q.st == B_UP || st_q.st == B_DOWN) begin
            phase_end = (ramp_dur == 12'h000) || (st_q.ms_tick && ph_next >= {1'b0, ramp_dur});
        end else begin
            phase_end = st_q.ms_tick && ph_next >= hold_dur;
        end
        cycle_last = (st_q.ctl[lfit_pkg::HI_MSB:lfit_pkg::HI_LSB] != 4'h0) &&
                     (st_q.cycles + 4'h1 >= st_q.ctl[lfit_pkg::HI_MSB:lfit_pkg::HI_LSB]);

        // Ramp stepping: one level step per cycle while the accumulator owes one
        if (st_q.ms_tick) begin
            st_d.ph_ms = ph_next;
            st_d.acc = st_q.acc + lfit_pkg::RAMP_STEP;
        end else if ((st_q.st == B_UP || st_q.st == B_DOWN) && ramp_dur != 12'h000 &&
                     st_q.acc >= {1'b0, ramp_dur}) begin
            st_d.acc = st_q.acc - {1'b0, ramp_dur};
            if (st_q.st == B_UP && st_q.lin != lfit_pkg::LEVEL_FULL) begin
                st_d.lin = st_q.lin + 8'h01;
            end else if (st_q.st == B_DOWN && st_q.lin != 8'h00) begin
                st_d.lin = st_q.lin - 8'h01;
            end
        end

        // Breath sequencer
        case (st_q.st)
            B_IDLE: begin
                st_d.lin = (enable && ind_mode == lfit_pkg::IND_CONSTANT_ON) ? lfit_pkg::LEVEL_FULL : 8'h00;
                if (enable && ind_mode[1] && !st_q.done) begin
                    st_d.st = B_UP;
                    st_d.ph_ms = 13'h0000;
                    st_d.acc = 13'h0000;
                    st_d.lin = 8'h00;
                    st_d.cycles = 4'h0;
                end
            end
            B_UP: if (phase_end) begin
                st_d.st = B_ON;
                st_d.ph_ms = 13'h0000;
                st_d.lin = lfit_pkg::LEVEL_FULL;
            end
            B_ON: if (phase_end) begin
                st_d.st = B_DOWN;
                st_d.ph_ms = 13'h0000;
                st_d.acc = 13'h0000;
            end
            B_DOWN: if (phase_end) begin
                st_d.st = B_OFF;
                st_d.ph_ms = 13'h0000;
                st_d.lin = 8'h00;
            end
            B_OFF: if (phase_end) begin
                st_d.ph_ms = 13'h0000;
                st_d.acc = 13'h0000;
                if (cycle_last) begin
                    st_d.done = 1'b1;
                    st_d.st = (ind_mode == lfit_pkg::IND_BREATH_TO_ON) ? B_HOLD : B_IDLE;
                    st_d.lin = (ind_mode == lfit_pkg::IND_BREATH_TO_ON) ? lfit_pkg::LEVEL_FULL : 8'h00;
                end else begin
                    st_d.st = B_UP;
                    st_d.cycles = st_q.cycles + 4'h1;
                end
            end
            B_HOLD: st_d.lin = lfit_pkg::LEVEL_FULL;
            default: st_d.st = B_IDLE;
        endcase

        // Leaving breath modes or disabling stops the sequence and rearms it
        if (!enable || !ind_mode[1]) begin
            st_d.st = B_IDLE;
            st_d.done = 1'b0;
            if (st_q.st != B_IDLE) begin
                st_d.lin = 8'h00;
            end
        end

        // Shape: square law stands in for the exponential curve, cheap and monotonic
        sq = st_q.lin * st_q.lin;
        if (st_q.ctl[lfit_pkg::CTL_SHAPE_BIT] && st_q.lin != lfit_pkg::LEVEL_FULL) begin
            st_d.level = sq[15:8];
        end else begin
            st_d.level = st_q.lin;
        end

        st_d.breathing = (st_d.st != B_IDLE) && (st_d.st != B_HOLD);
        if (soft_reset) begin
            st_d = reset_image();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; clock enable freezes everything
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= reset_image();
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

endmodule : lfit_regs

`default_nettype wire

/* sim/lfit_regs_asserts.sv */
// Concurrent checks on the ports of the timing register block
`timescale 1ns/1ps
`default_nettype none

module lfit_regs_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Enable, software reset and host byte port
    input wire logic clk_en,
    input wire logic soft_reset,
    input wire logic host_addr_load,
    input wire logic host_wr_stb,
    input wire logic host_rd_stb,
    input wire logic host_rd_valid_q,
    // Strobe
    input wire logic strobe_pin,
    input wire logic strobe_edge_mode,
    input wire logic strobe_trigger_q,
    // Decoded timing and indicator
    input wire logic [11:0] torch_ramp_ms_q,
    input wire logic [10:0] flash_timeout_ms_q,
    input wire logic [7:0] ind_level_q,
    input wire logic ind_breathing_q,
    input wire logic ind_breath_done_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    // A read that the port takes; higher priority strobes win
    sequence s_rd_taken;
        clk_en && host_rd_stb && !host_addr_load && !host_wr_stb && !soft_reset;
    endsequence
    // Level mode with a pin quiet long enough to pass the filter
    sequence s_pin_quiet;
        (!strobe_edge_mode && clk_en && $stable(strobe_pin)) [*8];
    endsequence

    chk_rd_latency: assert property (s_rd_taken |=> host_rd_valid_q)
        else $error("read taken without valid next cycle");
    chk_rd_spurious: assert property (host_rd_valid_q && $past(clk_en) |->
        $past(clk_en && host_rd_stb && !host_addr_load && !host_wr_stb)) else $error("valid without read");
    chk_torch_code: assert property (torch_ramp_ms_q inside {0, 1, 32, 64, 128, 256, 384, 512, 768,
        1024, 1280, 1536, 1792, 2048}) else $error("torch ramp outside table");
    chk_timeout_code: assert property (flash_timeout_ms_q inside {40, 80, 120, 160, 200, 240, 280,
        320, 360, 400, 1200, 1400, 1600}) else $error("flash time-out outside table");
    chk_strobe_level: assert property (s_pin_quiet |-> strobe_trigger_q == strobe_pin)
        else $error("level strobe does not follow pin");
    chk_strobe_pulse: assert property (strobe_edge_mode && clk_en && strobe_trigger_q |=> !strobe_trigger_q)
        else $error("edge strobe longer than one cycle");
    chk_soft_reset: assert property (soft_reset && clk_en |=> torch_ramp_ms_q == 12'h001
        && flash_timeout_ms_q == 11'h190 && !ind_breathing_q) else $error("soft reset not restoring");
    chk_done_rest: assert property (ind_breath_done_q |-> !ind_breathing_q
        && (ind_level_q == 8'h00 || ind_level_q == 8'hff)) else $error("done but not at rest level");
    chk_done_rise: assert property ($rose(ind_breath_done_q) |-> $past(ind_breathing_q))
        else $error("done without breathing");
endmodule : lfit_regs_asserts

bind lfit_regs lfit_regs_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .soft_reset(soft_reset), .host_addr_load(host_addr_load), .host_wr_stb(host_wr_stb),
    .host_rd_stb(host_rd_stb), .host_rd_valid_q(host_rd_valid_q), .strobe_pin(strobe_pin),
    .strobe_edge_mode(strobe_edge_mode), .strobe_trigger_q(strobe_trigger_q), .torch_ramp_ms_q(torch_ramp_ms_q),
    .flash_timeout_ms_q(flash_timeout_ms_q), .ind_level_q(ind_level_q), .ind_breathing_q(ind_breathing_q),
    .ind_breath_done_q(ind_breath_done_q));

`default_nettype wire

/* sim/lfit_host.sv */
// Host model driving the register byte port
`timescale 1ns/1ps
`default_nettype none

module lfit_host (
    // Clock
    input wire logic clk_sys,
    // Byte port towards the block
    output logic host_addr_load,
    output logic [7:0] host_addr,
    output logic host_wr_stb,
    output logic [7:0] host_wr_data,
    output logic host_rd_stb
);
    // Quiet port from time zero
    initial begin
        host_addr_load = 1'b0;
        host_addr = 8'h00;
        host_wr_stb = 1'b0;
        host_wr_data = 8'h00;
        host_rd_stb = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One cycle per call: 0 load, 1 write, 2 read, 3 idle; back to back relies on auto-increment
    task automatic op(input int k, input logic [7:0] v);
        @(posedge clk_sys);
        host_addr_load <= (k == 0);
        host_wr_stb <= (k == 1);
        host_rd_stb <= (k == 2);
        host_addr <= v;
        host_wr_data <= v;
    endtask : op
endmodule : lfit_host

`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the timing register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t %h %h", $time, g, e); end end

module tb;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
    localparam int RMP[16] = '{0, 1, 32, 64, 128, 256, 384, 512, 768, 1024, 1280, 1536, 1792, 2048, 2048, 2048};
    localparam int FB[5] = '{1, 2, 4, 64, 128};
    localparam logic [7:0] RV[7] = '{8'h1a, 8'h77, 8'h55, 8'h00, 8'h00, ID, 8'hff};
    localparam logic [7:0] WB[6] = '{8'hd3, 8'ha6, 8'h00, 8'hff, 8'hff, 8'h00};
    localparam logic [7:0] RB[6] = '{8'hd3, 8'ha6, 8'h00, 8'h00, ID, 8'hfc};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic soft_reset = 1'b0;
    logic strobe_pin = 1'b0;
    logic strobe_edge_mode = 1'b0;
    logic [4:0] fc = 5'h00;
    logic al, ws, rs, rv, trig, brth, done;
    logic [7:0] ad, wd, rdat, lvl;
    logic [1:0] llo;
    logic [11:0] trm;
    logic [10:0] fto;
    int errors = 0;
    int n_tests = 0;
    int n;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, host model and block
    always #5 clk_sys = ~clk_sys;
    lfit_host host (.clk_sys(clk_sys), .host_addr_load(al), .host_addr(ad), .host_wr_stb(ws),
        .host_wr_data(wd), .host_rd_stb(rs));
    // Short ms tick keeps breath runs to a few thousand cycles
    lfit_regs #(.CYC_PER_MS(10), .DEVICE_IDENTITY(ID)) uut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .soft_reset(soft_reset), .host_addr_load(al), .host_addr(ad), .host_wr_stb(ws), .host_wr_data(wd),
        .host_rd_stb(rs), .host_rd_data_q(rdat), .host_rd_valid_q(rv), .flash_timeout_cond(fc[4]),
        .input_voltage_flash_monitor_cond(fc[3]), .led_short_cond(fc[2]), .thermal_shutdown_cond(fc[1]),
        .undervoltage_lockout_cond(fc[0]), .strobe_pin(strobe_pin), .strobe_edge_mode(strobe_edge_mode),
        .strobe_trigger_q(trig), .torch_ramp_ms_q(trm), .flash_timeout_ms_q(fto), .ind_level_q(lvl),
        .ind_level_low_q(llo), .ind_breathing_q(brth), .ind_breath_done_q(done));

    ////////////////////////////////////////////////////////////////////////////
    // Access tasks
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick
    // Read at the current address; sampled half a cycle after the valid edge
    task automatic rd_nx(input logic [7:0] e);
        host.op(2, 8'h00);
        host.op(3, 8'h00);
        @(negedge clk_sys);
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask : rd_nx
    task automatic rd_at(input logic [7:0] a, input logic [7:0] e);
        host.op(0, a);
        rd_nx(e);
    endtask : rd_at
    task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
        host.op(0, a);
        host.op(1, d);
        host.op(3, 8'h00);
    endtask : wr_at
    // Breath run: mid-ramp level, on level, time to done, rest level
    task automatic breath(input logic [7:0] ctl, input int total, input int lo, input int hi, input logic [7:0] fin);
        wr_at(8'h0e, ctl);
        tick(160);
        @(negedge clk_sys);
        `CHK(lvl >= lo && lvl <= hi, 1'b1)
        `CHK(brth, 1'b1)
        tick(300);
        @(negedge clk_sys);
        `CHK(lvl, 8'hff)
        n = 460;
        while (done !== 1'b1 && n < total + 100) begin
            @(negedge clk_sys);
            n++;
        end
        // Phases may run up to one tick short each
        `CHK(n >= total - 80 && n <= total + 10, 1'b1)
        tick(2);
        @(negedge clk_sys);
        `CHK(lvl, fin)
        wr_at(8'h0e, 8'h00);
    endtask : breath
    task automatic test_done();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(10);
        resetn <= 1'b1;
        host.op(0, 8'h0b);
        for (int i = 0; i < 7; i++) rd_nx(RV[i]);
        `CHK(trm, 12'h001)
        `CHK(fto, 11'h190)
        for (int c = 0; c < 16; c++) begin
            wr_at(8'h0b, {c[3:0], c[3:0]});
            tick(2);
            @(negedge clk_sys);
            `CHK(trm, RMP[c])
            `CHK(fto, c < 10 ? (c + 1) * 40 : (c < 13 ? 400 : 1200 + (c - 13) * 200))
        end
        tick(1);
        soft_reset <= 1'b1;
        tick(1);
        soft_reset <= 1'b0;
        rd_at(8'h0b, 8'h1a);
        // Burst write runs over read-only places, then burst read back
        host.op(0, 8'h0c);
        for (int i = 0; i < 6; i++) host.op(1, WB[i]);
        host.op(0, 8'h0c);
        for (int i = 0; i < 6; i++) rd_nx(RB[i]);
        `CHK(llo, 2'h0)
        wr_at(8'h20, 8'h55);
        rd_at(8'h20, 8'h00);
        // Each fault stays until read, then clears
        for (int i = 0; i < 5; i++) begin
            tick(1);
            fc <= 5'h01 << i;
            tick(3);
            fc <= 5'h00;
            tick(8);
            rd_at(8'h0f, FB[i][7:0]);
            rd_at(8'h0f, 8'h00);
        end
        tick(1);
        fc <= 5'h10;
        tick(6);
        rd_at(8'h0f, 8'h80);
        rd_at(8'h0f, 8'h80);
        tick(1);
        fc <= 5'h00;
        strobe_pin <= 1'b1;
        tick(8);
        @(negedge clk_sys);
        `CHK(trig, 1'b1)
        tick(1);
        strobe_pin <= 1'b0;
        tick(8);
        strobe_edge_mode <= 1'b1;
        strobe_pin <= 1'b1;
        n = 0;
        repeat (12) begin
            @(posedge clk_sys);
            #1 if (trig === 1'b1) n++;
        end
        `CHK(n, 1)
        wr_at(8'h0c, 8'h21);
        wr_at(8'h0d, 8'h00);
        wr_at(8'h0e, 8'h03);
        tick(3);
        @(negedge clk_sys);
        `CHK(lvl, 8'hff)
        `CHK(brth, 1'b0)
        breath(8'h27, 3220, 100, 160, 8'hff);
        breath(8'h1d, 1610, 30, 100, 8'h00);
        test_done();
    end

    // Watchdog
    initial begin
        tick(20000);
        errors++;
        test_done();
    end
endmodule : tb

`default_nettype wire
